// *** design/ppc_pkg.sv ***
package ppc_pkg;

  // Register word indices; the byte address is four times the index
  localparam logic [7:0] PPC_RESISTOR_ASSIGN_OFS = 8'h2c;
  localparam logic [7:0] PPC_OPTIONS_TWO_OFS = 8'h38;
  localparam logic [7:0] PPC_SYS_CONFIG_OFS = 8'h3f;

  // Reset values
  localparam logic [7:0] PPC_RESISTOR_ASSIGN_RST = 8'h0f;
  localparam logic [7:0] PPC_OPTIONS_TWO_RST = 8'h00;
  localparam logic [7:0] PPC_SYS_CONFIG_RST = 8'h7f;

  // Implemented bit masks; config bits fixed high
  localparam logic [7:0] PPC_RESISTOR_ASSIGN_MASK = 8'h0f;
  localparam logic [7:0] PPC_OPTIONS_TWO_MASK = 8'hfc;
  localparam logic [7:0] PPC_SYS_CONFIG_FIXED = 8'h60;

  // Resistor assign fields
  localparam int PPC_PB_BIT = 0;
  localparam int PPC_PF_BIT = 1;
  localparam int PPC_PG_BIT = 2;
  localparam int PPC_PH_BIT = 3;

  // Options two fields
  localparam int PPC_OPT_SPR_BIT = 2;
  localparam int PPC_OPT_SHIFT_ORDER_SELECT_BIT = 3;
  localparam int PPC_OPT_IRV_BIT = 4;
  localparam int PPC_OPT_STR_BIT = 5;
  localparam int PPC_OPT_COD_BIT = 6;
  localparam int PPC_OPT_LIRD_BIT = 7;

  // System configuration fields
  localparam int PPC_CFG_EE_BIT = 0;
  localparam int PPC_CFG_ROM_BIT = 1;
  localparam int PPC_CFG_WDD_BIT = 2;
  localparam int PPC_CFG_SEC_BIT = 3;
  localparam int PPC_CFG_PEN_BIT = 4;
  localparam int PPC_CFG_MAP_BIT = 7;

  // AXI response codes
  localparam logic [1:0] PPC_RESP_OKAY = 2'h0;
  localparam logic [1:0] PPC_RESP_SLVERR = 2'h2;

  // Per-port pin direction and address claim
  typedef struct packed {
    logic [7:0] portB;
    logic [7:0] portF;
    logic [7:0] portG;
    logic [7:0] portH;
  } ppc_ports_t;

endpackage

// *** design/ppc_port_pullup_config.sv ***
// Register access over AXI4-Lite is this design's own decision.
`timescale 1ns/10ps
// Operation
// - Resistor assign bits 7..4 read zero regardless of writes.
// - One enable per port B, F, G, H; reset value low nibble ones.
// - Global enable zero disables all pull-ups; one lets port bits act.
// - Port H enable turns on pull-ups pins 7..4, pull-downs pins 3..0.
// - Expanded mode: port F and B enables have no effect.
// - Port C open-drain bit one makes port C outputs open-drain.
// - Stretch bit one lengthens off-chip accesses by one E cycle.
// - Outside single chip, visibility bit drives internal reads externally.
// - In single chip, visibility bit one holds E low, zero outputs E.
// - Shift order bit one sends LSB first, zero MSB first.
// - Line drive bit one also drives indicator pin high between pulses, else low only.
// - Options bits 1..0 read zero; reset clears all others, then bit 4 loads from the strap.
// - ROM map bit one puts ROM high; zero low, expanded mode only.
// - Watchdog disable bit one keeps watchdog inactive.
// - ROM enable bit places ROM in memory map.
// - EEPROM enable bit places EEPROM in memory map.
// - Security disable bit one turns off EEPROM security.
module ppc_port_pullup_config
  import ppc_pkg::*;
(
  input wire logic mclk,
  input wire logic rst_b,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic expandedMode,
  input wire logic [7:0] visibilityStrap,
  input wire ppc_ports_t pinIsOutput,
  input wire ppc_ports_t pinIsAddress,
  input wire logic eClock,
  input wire logic externalAccess,
  input wire logic internalRead,
  input wire logic [7:0] internalReadData,
  input wire logic [7:0] portCOut,
  input wire logic [7:0] portCDir,
  input wire logic fetchPulse,
  output ppc_ports_t pullUpOn,
  output logic [7:0] portHPullDownOn,
  output logic [7:0] portCPinOut,
  output logic [7:0] portCPinOe_b,
  output logic stretchCycle,
  output logic extDataDrive,
  output logic [7:0] extDataOut,
  output logic ePinOut,
  output logic shiftLsbFirst,
  output logic serialClockRateExtra,
  output logic fetchIndOut,
  output logic fetchIndOe_b,
  output logic romUpperHalf,
  output logic watchdogRun,
  output logic romPresent,
  output logic eepromPresent,
  output logic securityActive
);

  logic [7:0] resistorAssign_reg;
  logic [7:0] optionsTwo_reg;
  logic [7:0] sysConfig_reg;
  logic [7:0] awAddr_reg;
  logic awHeld_reg;
  logic [31:0] wData_reg;
  logic [3:0] wStrb_reg;
  logic wHeld_reg;
  logic bValid_reg;
  logic [1:0] bResp_reg;
  logic rValid_reg;
  logic [31:0] rData_reg;
  logic [1:0] rResp_reg;
  logic [7:0] strapSync1_reg;
  logic [7:0] strapSync2_reg;
  logic [2:0] strapAge_reg;
  logic doWrite;
  logic wrHit;
  logic [7:0] wByte;
  logic [7:0] rdValue;
  logic rdHit;
  logic globalOn;

  // Handshake outputs
  assign s_axi_awready = !awHeld_reg && !bValid_reg;
  assign s_axi_wready = !wHeld_reg && !bValid_reg;
  assign s_axi_bvalid = bValid_reg;
  assign s_axi_bresp = bResp_reg;
  assign s_axi_arready = !rValid_reg;
  assign s_axi_rvalid = rValid_reg;
  assign s_axi_rdata = rData_reg;
  assign s_axi_rresp = rResp_reg;

  // Write address capture
  always_ff @(posedge mclk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      awHeld_reg <= 1'b0;
      awAddr_reg <= 8'h00;
    end
    else if (s_axi_awvalid && s_axi_awready)
    begin
      awHeld_reg <= 1'b1;
      awAddr_reg <= s_axi_awaddr;
    end
    else if (doWrite)
    begin
      awHeld_reg <= 1'b0;
    end
  end

  // Write data capture
  always_ff @(posedge mclk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      wHeld_reg <= 1'b0;
      wData_reg <= 32'h0000_0000;
      wStrb_reg <= 4'h0;
    end
    else if (s_axi_wvalid && s_axi_wready)
    begin
      wHeld_reg <= 1'b1;
      wData_reg <= s_axi_wdata;
      wStrb_reg <= s_axi_wstrb;
    end
    else if (doWrite)
    begin
      wHeld_reg <= 1'b0;
    end
  end

  // Decode of a complete write
  assign doWrite = awHeld_reg && wHeld_reg;
  assign wByte = wData_reg[7:0];
  always_comb
  begin
    case (awAddr_reg[7:2])
      PPC_RESISTOR_ASSIGN_OFS[5:0],
      PPC_OPTIONS_TWO_OFS[5:0],
      PPC_SYS_CONFIG_OFS[5:0]: wrHit = 1'b1;
      default: wrHit = 1'b0;
    endcase
  end

  // Write response
  always_ff @(posedge mclk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      bValid_reg <= 1'b0;
      bResp_reg <= PPC_RESP_OKAY;
    end
    else if (doWrite)
    begin
      bValid_reg <= 1'b1;
      bResp_reg <= wrHit ? PPC_RESP_OKAY : PPC_RESP_SLVERR;
    end
    else if (s_axi_bready)
    begin
      bValid_reg <= 1'b0;
    end
  end

  // Resistor assign register
  always_ff @(posedge mclk or negedge rst_b)
  begin
    if (!rst_b)
      resistorAssign_reg <= PPC_RESISTOR_ASSIGN_RST;
    else if (doWrite && wStrb_reg[0] && awAddr_reg[7:2] == PPC_RESISTOR_ASSIGN_OFS[5:0])
      resistorAssign_reg <= wByte & PPC_RESISTOR_ASSIGN_MASK;
  end

  // Options two register; visibility bit loaded from strap after reset
  always_ff @(posedge mclk or negedge rst_b)
  begin
    if (!rst_b)
      optionsTwo_reg <= PPC_OPTIONS_TWO_RST;
    else if (doWrite && wStrb_reg[0] && awAddr_reg[7:2] == PPC_OPTIONS_TWO_OFS[5:0])
      optionsTwo_reg <= wByte & PPC_OPTIONS_TWO_MASK;
    else if (!strapAge_reg[2])
      optionsTwo_reg[PPC_OPT_IRV_BIT] <= strapSync2_reg[PPC_OPT_IRV_BIT];
  end

  // Strap synchroniser; capture runs for three edges after reset, the last taking the pin from the second stage
  always_ff @(posedge mclk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      strapSync1_reg <= 8'h00;
      strapSync2_reg <= 8'h00;
      strapAge_reg <= 3'b000;
    end
    else
    begin
      strapSync1_reg <= visibilityStrap;
      strapSync2_reg <= strapSync1_reg;
      strapAge_reg <= {strapAge_reg[1:0], 1'b1};
    end
  end

  // System configuration register, byte lane 0; bits 6..5 fixed high
  always_ff @(posedge mclk or negedge rst_b)
  begin
    if (!rst_b)
      sysConfig_reg <= PPC_SYS_CONFIG_RST;
    else if (doWrite && wStrb_reg[0] && awAddr_reg[7:2] == PPC_SYS_CONFIG_OFS[5:0])
      sysConfig_reg <= wByte | PPC_SYS_CONFIG_FIXED;
  end

  // Read mux
  always_comb
  begin
    rdValue = 8'h00;
    rdHit = 1'b1;
    case (s_axi_araddr[7:2])
      PPC_RESISTOR_ASSIGN_OFS[5:0]:
        rdValue = resistorAssign_reg & PPC_RESISTOR_ASSIGN_MASK;
      PPC_OPTIONS_TWO_OFS[5:0]: rdValue = optionsTwo_reg & PPC_OPTIONS_TWO_MASK;
      PPC_SYS_CONFIG_OFS[5:0]: rdValue = sysConfig_reg;
      default: rdHit = 1'b0;
    endcase
  end

  // Read response
  always_ff @(posedge mclk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      rValid_reg <= 1'b0;
      rData_reg <= 32'h0000_0000;
      rResp_reg <= PPC_RESP_OKAY;
    end
    else if (s_axi_arvalid && s_axi_arready)
    begin
      rValid_reg <= 1'b1;
      rResp_reg <= rdHit ? PPC_RESP_OKAY : PPC_RESP_SLVERR;
      rData_reg <= {24'h00_0000, rdValue};
    end
    else if (s_axi_rready)
    begin
      rValid_reg <= 1'b0;
    end
  end

  // Pull resistor enables
  assign globalOn = sysConfig_reg[PPC_CFG_PEN_BIT];
  always_ff @(posedge mclk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      pullUpOn <= '0;
      portHPullDownOn <= 8'h00;
    end
    else
    begin
      pullUpOn.portB <= {8{globalOn && resistorAssign_reg[PPC_PB_BIT] && !expandedMode}}
        & ~pinIsOutput.portB & ~pinIsAddress.portB;
      pullUpOn.portF <= {8{globalOn && resistorAssign_reg[PPC_PF_BIT] && !expandedMode}}
        & ~pinIsOutput.portF & ~pinIsAddress.portF;
      pullUpOn.portG <= {8{globalOn && resistorAssign_reg[PPC_PG_BIT]}}
        & ~pinIsOutput.portG & ~pinIsAddress.portG;
      pullUpOn.portH <= {{4{globalOn && resistorAssign_reg[PPC_PH_BIT]}}, 4'h0}
        & ~pinIsOutput.portH & ~pinIsAddress.portH;
      portHPullDownOn <= {4'h0, {4{globalOn && resistorAssign_reg[PPC_PH_BIT]}}}
        & ~pinIsOutput.portH & ~pinIsAddress.portH;
    end
  end

  // Port C drive, open-drain when selected
  always_ff @(posedge mclk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      portCPinOut <= 8'h00;
      portCPinOe_b <= 8'hff;
    end
    else if (optionsTwo_reg[PPC_OPT_COD_BIT])
    begin
      portCPinOut <= 8'h00;
      portCPinOe_b <= ~(portCDir & ~portCOut);
    end
    else
    begin
      portCPinOut <= portCOut;
      portCPinOe_b <= ~portCDir;
    end
  end

  // Bus timing, visibility and E pin
  always_ff @(posedge mclk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      stretchCycle <= 1'b0;
      extDataDrive <= 1'b0;
      extDataOut <= 8'h00;
      ePinOut <= 1'b0;
    end
    else
    begin
      stretchCycle <= externalAccess && optionsTwo_reg[PPC_OPT_STR_BIT];
      extDataDrive <= expandedMode && internalRead && optionsTwo_reg[PPC_OPT_IRV_BIT];
      extDataOut <= internalReadData;
      if (!expandedMode)
        ePinOut <= optionsTwo_reg[PPC_OPT_IRV_BIT] ? 1'b0 : eClock;
      else
        ePinOut <= eClock;
    end
  end

  // Serial options and fetch indicator drive
  always_ff @(posedge mclk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      shiftLsbFirst <= 1'b0;
      serialClockRateExtra <= 1'b0;
      fetchIndOut <= 1'b0;
      fetchIndOe_b <= 1'b1;
    end
    else
    begin
      shiftLsbFirst <= optionsTwo_reg[PPC_OPT_SHIFT_ORDER_SELECT_BIT];
      serialClockRateExtra <= optionsTwo_reg[PPC_OPT_SPR_BIT];
      fetchIndOut <= !fetchPulse;
      // High side only driven when selected
      fetchIndOe_b <= !(fetchPulse || optionsTwo_reg[PPC_OPT_LIRD_BIT]);
    end
  end

  // Memory map and system controls
  always_ff @(posedge mclk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      romUpperHalf <= 1'b1;
      watchdogRun <= 1'b0;
      romPresent <= 1'b0;
      eepromPresent <= 1'b0;
      securityActive <= 1'b1;
    end
    else
    begin
      romUpperHalf <= sysConfig_reg[PPC_CFG_MAP_BIT] || !expandedMode;
      watchdogRun <= !sysConfig_reg[PPC_CFG_WDD_BIT];
      romPresent <= sysConfig_reg[PPC_CFG_ROM_BIT];
      eepromPresent <= sysConfig_reg[PPC_CFG_EE_BIT];
      securityActive <= !sysConfig_reg[PPC_CFG_SEC_BIT];
    end
  end

endmodule

// *** tb/ppc_port_pullup_config_assertions.sv ***
`timescale 1ns/10ps
module ppc_port_pullup_config_assertions
  import ppc_pkg::*;
(
  input wire logic mclk,
  input wire logic rst_b,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic expandedMode,
  input wire ppc_ports_t pinIsOutput,
  input wire ppc_ports_t pinIsAddress,
  input wire logic eClock,
  input wire logic externalAccess,
  input wire logic internalRead,
  input wire ppc_ports_t pullUpOn,
  input wire logic [7:0] portHPullDownOn,
  input wire logic stretchCycle,
  input wire logic extDataDrive,
  input wire logic ePinOut
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_b);
  // Both write halves taken together
  sequence sWrTaken;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  // Response raised on the second edge
  sequence sWrAnswer;
    !s_axi_bvalid ##1 s_axi_bvalid;
  endsequence
  AST_WR_RESP: assert property (sWrTaken |=> sWrAnswer)
    else $error("write response timing wrong");
  AST_RD_RESP: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read data late");
  AST_PH_SPLIT: assert property (pullUpOn.portH[3:0] == 4'h0 && portHPullDownOn[7:4] == 4'h0)
    else $error("port H resistor split wrong");
  AST_PIN_FREE: assert property ($past(rst_b) && $stable(pinIsOutput) && $stable(pinIsAddress)
    |-> (pullUpOn & (pinIsOutput | pinIsAddress)) == 32'h0000_0000)
    else $error("pull-up on a driven or address pin");
  AST_EXP_BF: assert property ($past(rst_b) && $past(expandedMode) |-> pullUpOn.portB == 8'h00 && pullUpOn.portF == 8'h00)
    else $error("address port pulled up");
  AST_STRETCH: assert property (stretchCycle |-> $past(externalAccess))
    else $error("stretch without external access");
  AST_VIS: assert property (extDataDrive |-> $past(expandedMode) && $past(internalRead))
    else $error("visibility drive without cause");
  AST_E_PIN: assert property ($past(rst_b) && $past(expandedMode) |-> ePinOut == $past(eClock))
    else $error("E pin not following E clock");
endmodule

// *** tb/ppc_port_pullup_config_tb.sv ***
`timescale 1ns/10ps
module ppc_port_pullup_config_tb
  import ppc_pkg::*;
;
  localparam logic [1:0] OK = PPC_RESP_OKAY;
  localparam logic [7:0] ASN = {PPC_RESISTOR_ASSIGN_OFS[5:0], 2'b00};
  localparam logic [7:0] OPT = {PPC_OPTIONS_TWO_OFS[5:0], 2'b00};
  localparam logic [7:0] CFG = {PPC_SYS_CONFIG_OFS[5:0], 2'b00};
  logic mclk, rst_b, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid;
  logic s_axi_rready, expandedMode, eClock, externalAccess, internalRead, fetchPulse;
  logic [7:0] s_axi_awaddr, s_axi_araddr, visibilityStrap, internalReadData, portCOut;
  logic [7:0] portCDir, portHPullDownOn, portCPinOut, portCPinOe_b, extDataOut;
  logic [31:0] s_axi_wdata, s_axi_rdata, rd;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  ppc_ports_t pinIsOutput, pinIsAddress, pullUpOn;
  logic stretchCycle, extDataDrive, ePinOut, shiftLsbFirst, serialClockRateExtra;
  logic fetchIndOut, fetchIndOe_b, romUpperHalf, watchdogRun, romPresent;
  logic eepromPresent, securityActive;
  int mismatches, samples_checked;
  ppc_port_pullup_config u_dut (.*);
  // Clock
  initial
  begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end
  task automatic stop_test;
    $display("mismatches %0d samples_checked %0d", mismatches, samples_checked);
    if (mismatches == 0 && samples_checked > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
    samples_checked++;
    if (s !== e)
    begin
      mismatches++;
      $display("BAD %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic tmo(input int n);
    if (n >= 50)
    begin
      mismatches++;
      stop_test();
    end
  endtask
  // Bus write, both halves offered together
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
    input logic [1:0] er);
    int n;
    n = 0;
    @(posedge mclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_wstrb <= s;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do
    begin
      @(posedge mclk);
      n++;
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid && n < 50);
    s_axi_bready <= 1'b0;
    tmo(n);
    chk("bresp", er, s_axi_bresp);
  endtask
  // Bus read into rd
  task automatic rdr(input logic [7:0] a, input logic [1:0] er);
    int n;
    n = 0;
    @(posedge mclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do
    begin
      @(posedge mclk);
      n++;
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid && n < 50);
    rd = s_axi_rdata;
    s_axi_rready <= 1'b0;
    tmo(n);
    chk("rresp", er, s_axi_rresp);
  endtask
  // Outputs lag inputs by up to two edges
  task automatic settle;
    repeat (3) @(posedge mclk);
  endtask
  task automatic t_reset;
    rdr(ASN, OK);
    chk("assign", 8'h0f, rd[7:0]);
    rdr(OPT, OK);
    chk("options", 8'h10, rd[7:0]);
    rdr(CFG, OK);
    chk("config", PPC_SYS_CONFIG_RST, rd[7:0]);
    chk("rom_present", 1'b1, romPresent);
    chk("eeprom_present", 1'b1, eepromPresent);
  endtask
  task automatic t_pull;
    wr(ASN, 32'h0000_00ff, 4'h1, OK);
    rdr(ASN, OK);
    chk("assignHi", 8'h0f, rd[7:0]);
    @(posedge mclk);
    pinIsOutput.portG <= 8'h0f;
    pinIsAddress.portH <= 8'h80;
    settle();
    chk("pullPin", 32'hffff_f070, pullUpOn);
    chk("pullDown", 8'h0f, portHPullDownOn);
    wr(ASN, 32'h0000_0006, 4'h1, OK);
    settle();
    chk("pullPort", 32'h00ff_f000, pullUpOn);
    wr(ASN, 32'h0000_000f, 4'h1, OK);
    @(posedge mclk);
    expandedMode <= 1'b1;
    settle();
    chk("pullExp", 32'h0000_f070, pullUpOn);
    wr(CFG, 32'h0000_006f, 4'h1, OK);
    settle();
    chk("pullOff", 32'h0000_0000, pullUpOn);
    chk("downOff", 8'h00, portHPullDownOn);
  endtask
  task automatic t_opt;
    wr(OPT, 32'h0000_00ff, 4'h1, OK);
    rdr(OPT, OK);
    chk("optLow", 8'hfc, rd[7:0]);
    @(posedge mclk);
    {externalAccess, internalRead, eClock} <= 3'h7;
    portCDir <= 8'hff;
    settle();
    chk("visDrv", 1'b1, extDataDrive);
    chk("visDat", 8'ha5, extDataOut);
    chk("lsb", 1'b1, shiftLsbFirst);
    chk("stretch", 1'b1, stretchCycle);
    chk("cOe", 8'h0f, portCPinOe_b);
    chk("cOut", 8'h00, portCPinOut);
    chk("lirOe", 2'b10, {fetchIndOut, fetchIndOe_b});
    chk("spr", 1'b1, serialClockRateExtra);
    @(posedge mclk);
    expandedMode <= 1'b0;
    settle();
    chk("eLow", 1'b0, ePinOut);
    wr(OPT, 32'h0000_0000, 4'h1, OK);
    @(posedge mclk);
    fetchPulse <= 1'b1;
    settle();
    chk("eClk", 1'b1, ePinOut);
    chk("msb", 1'b0, shiftLsbFirst);
    chk("noStretch", 1'b0, stretchCycle);
    chk("cOeN", 8'h00, portCPinOe_b);
    chk("cOutN", 8'h0f, portCPinOut);
    chk("lirLow", 2'b00, {fetchIndOut, fetchIndOe_b});
  endtask
  task automatic t_cfg;
    wr(CFG, 32'h0000_0083, 4'h1, OK);
    settle();
    chk("cfgOn", 4'hf, {romUpperHalf, watchdogRun, securityActive, romPresent});
    @(posedge mclk);
    expandedMode <= 1'b1;
    wr(CFG, 32'h0000_000c, 4'h1, OK);
    settle();
    chk("cfgOff", 5'h00, {romUpperHalf, watchdogRun, securityActive, romPresent,
      eepromPresent});
    wr(8'h40, 32'h0000_0000, 4'hf, PPC_RESP_SLVERR);
    rdr(8'h40, PPC_RESP_SLVERR);
  endtask
  // Main sequence
  initial
  begin
    mismatches = 0;
    samples_checked = 0;
    rst_b = 1'b0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
    {expandedMode, eClock, externalAccess, internalRead, fetchPulse} = 5'h00;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb, portCDir} = 60'h0;
    {pinIsOutput, pinIsAddress} = 64'h0;
    visibilityStrap = 8'h10;
    internalReadData = 8'ha5;
    portCOut = 8'h0f;
    repeat (16) @(posedge mclk);
    rst_b <= 1'b1;
    repeat (4) @(posedge mclk);
    t_reset();
    t_pull();
    t_opt();
    t_cfg();
    stop_test();
  end
endmodule
bind ppc_port_pullup_config ppc_port_pullup_config_assertions u_chk (.*);
